// File: core/iab_core.sv
// integer add, branch, load/store sizing and system register execution core
// Function
// - stall consumer of immediately preceding load
// - translation miss fails access, takes exception
// - cacheable load returns and fills whole word
// - store byte enables from size, address
// - word and doubleword access sizes, four and eight bytes
// - address selects lowest-addressed, rightmost byte
// - used bytes from size, three address bits
// - branches delay exactly one instruction
// - slot exception returns to preceding branch
// - misaligned register jump faults on fetch
// - system registers only via move instructions
// - trapping register add overflow, no write
// - sign-extend 32-bit add result to 64 in 64-bit mode, zero-extend otherwise
// - trapping immediate add, sign-extended immediate
// - non-trapping immediate add never traps
// - non-trapping register add never traps
`timescale 1ns/100ps
module iab_core
    import iab_pkg::*;
(
    input  wire logic        mclk,           // core clock
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic        mode64,         // 64-bit operation mode
    input  wire logic        mode16,         // 16-bit instruction mode
    output logic [63:0]      fetchAddr,      // instruction fetch address
    output logic             fetchReq,       // fetch request
    input  wire logic [31:0] fetchInstr,     // fetched instruction
    input  wire logic        fetchValid,     // fetched instruction valid
    output logic [63:0]      memVirtAddr,    // data virtual address
    output logic             memReq,         // data access request
    output logic             memWrite,       // store when high
    output logic [2:0]       memSize,        // access size, bytes minus one
    output logic [7:0]       memByteEn,      // byte lanes within doubleword
    output logic [63:0]      memWrData,      // store data, lane aligned
    output logic             memFill,        // fill whole word into cache
    input  wire logic        xlateHit,       // translation buffer hit
    input  wire logic        memCacheable,   // access is cacheable
    input  wire logic        memDone,        // access completed
    input  wire logic [63:0] memRdData,      // load data, lane aligned
    output logic             excTaken,       // exception pulse
    output logic [3:0]       excCode,        // exception cause
    output logic [63:0]      excReturnAddr,  // exception return address
    output logic             excInSlot       // faulting instruction was in a slot
);
    iab_reg_if rf ();
    iab_regfile uRegs (.mclk(mclk), .rst_n(rst_n), .rf(rf));

    iab_state_t  state;
    logic [63:0] pc;
    logic [63:0] instrPc;
    logic [31:0] instr;
    logic        instrValid;
    logic        inSlot;
    logic [63:0] branchPc;
    logic        prevLoad;
    logic [4:0]  prevLoadDst;
    logic        fetchAlignFault;
    logic [63:0] sysReg [0:SYSREG_COUNT-1];

    logic [5:0]  opcode;
    logic [4:0]  srcA;
    logic [4:0]  srcB;
    logic [4:0]  dst;
    logic [5:0]  funct;
    logic [15:0] imm;
    assign opcode = instr[OPC_HI:OPC_LO];
    assign srcA   = instr[SRC1_HI:SRC1_LO];
    assign srcB   = instr[SRC2_HI:SRC2_LO];
    assign dst    = instr[DST_HI:DST_LO];
    assign funct  = instr[FN_HI:FN_LO];
    assign imm    = instr[15:0];

    // lanes depend only on size and low three address bits
    function automatic logic [7:0] byte_lanes(input logic [2:0] size, input logic [2:0] addrLo);
        logic [15:0] span;
        span = {8'h00, 8'hff >> (3'h7 - size)} << addrLo;
        return span[7:0];
    endfunction

    // sign extension of a 32-bit result
    function automatic logic [63:0] sext32(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction

    function automatic logic [63:0] sext16(input logic [15:0] v);
        return {{48{v[15]}}, v};
    endfunction

    logic isSpecial;
    logic isAddReg;
    logic isAddImm;
    logic trapsOnOvf;
    logic isLoad;
    logic isStore;
    logic isJumpReg;
    logic isBranch;
    logic isSysMove;
    logic isCopMem;
    logic usesSrcB;
    logic linkWrites;
    assign isSpecial  = opcode == OP_SPECIAL;
    assign isAddReg   = isSpecial && (funct == FN_ADD_TRAP || funct == FN_ADD_NOTRAP);
    assign isAddImm   = opcode == OP_ADD_IMMEDIATE_TRAPPING_TRAP || opcode == OP_ADD_IMMEDIATE_TRAPPING_NOTRAP;
    assign trapsOnOvf = (isSpecial && funct == FN_ADD_TRAP) || opcode == OP_ADD_IMMEDIATE_TRAPPING_TRAP;
    assign isLoad     = opcode == OP_LOAD_WORD || opcode == OP_LOAD_DWORD;
    assign isStore    = opcode == OP_STORE_WORD || opcode == OP_STORE_DWORD;
    assign isJumpReg  = isSpecial && (funct == FN_JUMP_REG || funct == FN_JUMP_REG_LINK);
    assign isBranch   = isJumpReg || opcode == OP_JUMP || opcode == OP_JUMP_LINK
                        || opcode == OP_BRANCH_EQ || opcode == OP_BRANCH_NE;
    assign isSysMove  = opcode == OP_COPROC_SYS && (srcA == CS_MOVE_FROM || srcA == CS_MOVE_TO);
    assign isCopMem   = opcode == OP_COP_LOAD || opcode == OP_COP_STORE;
    assign usesSrcB   = isSpecial || isStore || opcode == OP_BRANCH_EQ || opcode == OP_BRANCH_NE
                        || isSysMove;
    assign linkWrites = opcode == OP_JUMP_LINK || (isSpecial && funct == FN_JUMP_REG_LINK);

    logic hazard;
    assign hazard = instrValid && prevLoad && prevLoadDst != 5'h00
                    && (prevLoadDst == srcA || (usesSrcB && prevLoadDst == srcB));

    // adder: operands expected sign-extended, only low 32 bits matter
    logic [31:0] opA;
    logic [31:0] opB;
    logic [32:0] sum;
    logic        ovf;
    assign opA = rf.rdDataA[31:0];
    assign opB = isAddImm ? {{16{imm[15]}}, imm} : rf.rdDataB[31:0];
    assign sum = {1'b0, opA} + {1'b0, opB};
    // carry out of bit 30 differs from carry out of bit 31
    assign ovf = (opA[31] == opB[31]) && (sum[31] != opA[31]);

    logic [63:0] addResult;
    assign addResult = mode64 ? sext32(sum[31:0]) : {32'h0, sum[31:0]};

    logic [63:0] effAddr;
    assign effAddr = rf.rdDataA + sext16(imm);

    logic [63:0] jumpTarget;
    always_comb begin
        jumpTarget = pc + {{46{imm[15]}}, imm, 2'b00};
        if (isJumpReg) begin
            jumpTarget = rf.rdDataA;
        end else if (opcode == OP_JUMP || opcode == OP_JUMP_LINK) begin
            jumpTarget = {pc[63:28], instr[25:0], 2'b00};
        end
    end

    logic branchTaken;
    always_comb begin
        branchTaken = 1'b1;
        if (opcode == OP_BRANCH_EQ) begin
            branchTaken = rf.rdDataA == rf.rdDataB;
        end else if (opcode == OP_BRANCH_NE) begin
            branchTaken = rf.rdDataA != rf.rdDataB;
        end
    end

    logic [2:0] accSize;
    assign accSize = (opcode == OP_LOAD_DWORD || opcode == OP_STORE_DWORD) ? SZ_DWORD : SZ_WORD;

    logic [63:0] restartPc;
    // slot fault restarts at the branch
    assign restartPc = inSlot ? branchPc : instrPc;

    logic issue;
    // a branch waits for its slot, so the target fetch follows the slot directly
    assign issue = state == ST_RUN && instrValid && !hazard && (fetchValid || !isBranch);

    logic       raiseExc;
    iab_exc_t   raiseCode;
    always_comb begin
        raiseExc  = 1'b0;
        raiseCode = EXC_NONE;
        if (issue) begin
            if (fetchAlignFault) begin
                raiseExc  = 1'b1;
                raiseCode = EXC_ADDR_FETCH;
            end else if (trapsOnOvf && ovf) begin
                raiseExc  = 1'b1;
                raiseCode = EXC_OVERFLOW;
            // coprocessor loads and stores are not a path to system registers
            end else if (isCopMem) begin
                raiseExc  = 1'b1;
                raiseCode = EXC_RESERVED;
            end
        end else if (state == ST_MEM && !xlateHit) begin
            raiseExc  = 1'b1;
            raiseCode = EXC_TRANSLATE;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
        end else begin
            case (state)
                ST_RUN: begin
                    if (raiseExc) begin
                        state <= ST_TRAP;
                    end else if (instrValid && hazard) begin
                        state <= ST_STALL;
                    end else if (issue && (isLoad || isStore)) begin
                        state <= ST_MEM;
                    end
                end
                ST_STALL: state <= ST_RUN;
                ST_MEM: begin
                    if (raiseExc) begin
                        state <= ST_TRAP;
                    end else if (memDone) begin
                        state <= ST_RUN;
                    end
                end
                ST_TRAP: state <= ST_RUN;
                default: state <= ST_RUN;
            endcase
        end
    end

    // interlock clears after one ST_STALL cycle, or when the next instruction issues
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prevLoad    <= 1'b0;
            prevLoadDst <= 5'h00;
        end else if (state == ST_STALL) begin
            prevLoad <= 1'b0;
        end else if (issue) begin
            prevLoad    <= isLoad;
            prevLoadDst <= srcB;
        end
    end

    logic advance;
    assign advance = (issue && !(isLoad || isStore) && !raiseExc)
                     || (state == ST_MEM && memDone && xlateHit) || state == ST_TRAP;

    // operands follow the held instruction, not the fetch bus, while it waits
    logic        accept;
    logic [31:0] readInstr;
    assign accept     = fetchValid && (advance || !instrValid);
    assign readInstr  = accept ? fetchInstr : instr;
    assign rf.rdAddrA = readInstr[SRC1_HI:SRC1_LO];
    assign rf.rdAddrB = readInstr[SRC2_HI:SRC2_LO];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            instr      <= 32'h0;
            instrValid <= 1'b0;
            instrPc    <= PC_RESET;
        end else if (state == ST_TRAP) begin
            instrValid <= 1'b0;
        end else if (accept) begin
            instr      <= fetchInstr;
            instrValid <= 1'b1;
            instrPc    <= pc;
        end else if (advance) begin
            instrValid <= 1'b0;
        end
    end

    // slot instruction runs, target fetched after it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc              <= PC_RESET;
            inSlot          <= 1'b0;
            branchPc        <= 64'h0;
            fetchAlignFault <= 1'b0;
        end else if (state == ST_TRAP) begin
            pc         <= PC_RESET;
            inSlot     <= 1'b0;
        end else if (accept) begin
            inSlot          <= issue && isBranch;
            fetchAlignFault <= mode16 ? pc[0] : (pc[1:0] != 2'b00);
            pc              <= (issue && isBranch && branchTaken) ? jumpTarget : pc + PC_STEP;
            if (issue && isBranch) begin
                // a branch in a slot is not checked
                branchPc <= instrPc;
            end
        end
    end

    assign fetchAddr = pc;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fetchReq <= 1'b0;
        end else begin
            fetchReq <= state != ST_TRAP;
        end
    end

    // data access request, held until done or a translation miss
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            memReq      <= 1'b0;
            memWrite    <= 1'b0;
            memSize     <= SZ_WORD;
            memByteEn   <= 8'h00;
            memWrData   <= 64'h0;
            memVirtAddr <= 64'h0;
            memFill     <= 1'b0;
        end else if (issue && (isLoad || isStore) && !raiseExc) begin
            memReq      <= 1'b1;
            memWrite    <= isStore;
            // size code from the access type
            memSize     <= accSize;
            // lanes start at the lowest addressed byte
            memByteEn   <= byte_lanes(accSize, effAddr[2:0]);
            memWrData   <= rf.rdDataB << {effAddr[2:0], 3'b000};
            memVirtAddr <= effAddr;
        end else if (state == ST_MEM) begin
            // cacheable load takes and fills the whole word
            memFill <= !memWrite && memCacheable && xlateHit;
            if (memDone || !xlateHit) begin
                memReq  <= 1'b0;
                memFill <= 1'b0;
            end
        end
    end

    // register write-back
    logic [63:0] loadData;
    assign loadData = memRdData >> {memVirtAddr[2:0], 3'b000};

    always_comb begin
        rf.wrEn   = 1'b0;
        rf.wrAddr = 5'h00;
        rf.wrData = addResult;
        if (state == ST_MEM && memDone && xlateHit && !memWrite) begin
            rf.wrEn   = 1'b1;
            rf.wrAddr = prevLoadDst;
            rf.wrData = memSize == SZ_WORD ? sext32(loadData[31:0]) : loadData;
        end else if (issue && !raiseExc) begin
            if (isAddReg) begin
                rf.wrEn   = 1'b1;
                rf.wrAddr = dst;
            end else if (isAddImm) begin
                rf.wrEn   = 1'b1;
                rf.wrAddr = srcB;
            end else if (linkWrites) begin
                // link source restriction left to software
                rf.wrEn   = 1'b1;
                rf.wrAddr = isJumpReg ? dst : LINK_REG;
                rf.wrData = instrPc + PC_STEP + PC_STEP;
            end else if (isSysMove && srcA == CS_MOVE_FROM) begin
                rf.wrEn   = 1'b1;
                rf.wrAddr = srcB;
                rf.wrData = sysReg[dst];
            end
        end
    end

    // system registers written only by the move-to instruction
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SYSREG_COUNT; i++) begin
                sysReg[i] <= 64'h0;
            end
        end else if (issue && !raiseExc && isSysMove && srcA == CS_MOVE_TO) begin
            sysReg[dst] <= rf.rdDataB;
        end
    end

    // exception report
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            excTaken      <= 1'b0;
            excCode       <= EXC_NONE;
            excReturnAddr <= 64'h0;
            excInSlot     <= 1'b0;
        end else begin
            excTaken <= raiseExc;
            if (raiseExc) begin
                excCode       <= raiseCode;
                excReturnAddr <= restartPc;
                excInSlot     <= inSlot;
            end
        end
    end
endmodule

// File: core/iab_pkg.sv
// package: shared constants and types for the add and branch execution block
package iab_pkg;
    localparam logic [5:0]  OP_SPECIAL     = 6'h00;
    localparam logic [5:0]  OP_ADD_IMMEDIATE_TRAPPING_TRAP   = 6'h08;
    localparam logic [5:0]  OP_ADD_IMMEDIATE_TRAPPING_NOTRAP = 6'h09;
    localparam logic [5:0]  OP_JUMP        = 6'h02;
    localparam logic [5:0]  OP_JUMP_LINK   = 6'h03;
    localparam logic [5:0]  OP_BRANCH_EQ   = 6'h04;
    localparam logic [5:0]  OP_BRANCH_NE   = 6'h05;
    localparam logic [5:0]  OP_LOAD_WORD   = 6'h23;
    localparam logic [5:0]  OP_LOAD_DWORD  = 6'h37;
    localparam logic [5:0]  OP_STORE_WORD  = 6'h2b;
    localparam logic [5:0]  OP_STORE_DWORD = 6'h3f;
    localparam logic [5:0]  OP_COPROC_SYS  = 6'h10;
    localparam logic [5:0]  OP_COP_LOAD    = 6'h31;
    localparam logic [5:0]  OP_COP_STORE   = 6'h39;
    localparam logic [5:0]  FN_ADD_TRAP    = 6'h20;
    localparam logic [5:0]  FN_ADD_NOTRAP  = 6'h21;
    localparam logic [5:0]  FN_JUMP_REG    = 6'h08;
    localparam logic [5:0]  FN_JUMP_REG_LINK = 6'h09;
    localparam logic [4:0]  CS_MOVE_FROM   = 5'h00;
    localparam logic [4:0]  CS_MOVE_TO     = 5'h04;
    localparam int          OPC_HI = 31;
    localparam int          OPC_LO = 26;
    localparam int          SRC1_HI = 25;
    localparam int          SRC1_LO = 21;
    localparam int          SRC2_HI = 20;
    localparam int          SRC2_LO = 16;
    localparam int          DST_HI = 15;
    localparam int          DST_LO = 11;
    localparam int          FN_HI = 5;
    localparam int          FN_LO = 0;
    localparam logic [4:0]  LINK_REG       = 5'h1f;
    localparam logic [63:0] PC_RESET       = 64'hffff_ffff_bfc0_0000;
    localparam logic [63:0] PC_STEP        = 64'h0000_0000_0000_0004;
    localparam int          SYSREG_COUNT   = 32;
    // access size codes, value is bytes minus one
    typedef enum logic [2:0] {
        SZ_BYTE = 3'h0, SZ_HALF = 3'h1, SZ_THREE = 3'h2, SZ_WORD = 3'h3,
        SZ_FIVE = 3'h4, SZ_SIX = 3'h5, SZ_SEVEN = 3'h6, SZ_DWORD = 3'h7
    } iab_size_t;
    typedef enum logic [3:0] {
        EXC_NONE = 4'h0, EXC_OVERFLOW = 4'h1, EXC_ADDR_FETCH = 4'h2,
        EXC_TRANSLATE = 4'h3, EXC_RESERVED = 4'h4
    } iab_exc_t;
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_STALL = 4'b0010,
        ST_MEM   = 4'b0100,
        ST_TRAP  = 4'b1000
    } iab_state_t;
endpackage

// File: core/iab_reg_if.sv
// interface: register file port bundle between core and register file
`timescale 1ns/100ps
interface iab_reg_if;
    logic [4:0]  rdAddrA;
    logic [4:0]  rdAddrB;
    logic [63:0] rdDataA;
    logic [63:0] rdDataB;
    logic        wrEn;
    logic [4:0]  wrAddr;
    logic [63:0] wrData;
    modport core (output rdAddrA, output rdAddrB, input rdDataA, input rdDataB,
                  output wrEn, output wrAddr, output wrData);
    modport store (input rdAddrA, input rdAddrB, output rdDataA, output rdDataB,
                   input wrEn, input wrAddr, input wrData);
endinterface

// File: core/iab_regfile.sv
// general register file, two registered read ports and one write port
`timescale 1ns/100ps
module iab_regfile
    import iab_pkg::*;
(
    input  wire logic mclk,   // core clock
    input  wire logic rst_n,  // async reset, active low
    iab_reg_if.store  rf      // register port bundle
);
    logic [63:0] mem [0:31];

    // register zero reads as zero, writes to it are dropped
    always_ff @(posedge mclk) begin
        if (rf.wrEn && rf.wrAddr != 5'h00) begin
            mem[rf.wrAddr] <= rf.wrData;
        end
    end

    // write-through bypass so a read in the write cycle sees new data
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rf.rdDataA <= 64'h0;
            rf.rdDataB <= 64'h0;
        end else begin
            if (rf.rdAddrA == 5'h00) begin
                rf.rdDataA <= 64'h0;
            end else if (rf.wrEn && rf.wrAddr == rf.rdAddrA) begin
                rf.rdDataA <= rf.wrData;
            end else begin
                rf.rdDataA <= mem[rf.rdAddrA];
            end
            if (rf.rdAddrB == 5'h00) begin
                rf.rdDataB <= 64'h0;
            end else if (rf.wrEn && rf.wrAddr == rf.rdAddrB) begin
                rf.rdDataB <= rf.wrData;
            end else begin
                rf.rdDataB <= mem[rf.rdAddrB];
            end
        end
    end
endmodule

// File: tb/iab_core_monitor.sv
// checker: data access and exception properties at the core ports
`timescale 1ns/100ps
module iab_core_monitor
    import iab_pkg::*;
(
    input wire logic        mclk,        // clock
    input wire logic        rst_n,       // reset
    input wire logic [63:0] memVirtAddr, // address
    input wire logic        memReq,      // request
    input wire logic        memWrite,    // store
    input wire logic [2:0]  memSize,     // size code
    input wire logic [7:0]  memByteEn,   // lanes
    input wire logic        memFill,     // fill
    input wire logic        xlateHit,    // hit
    input wire logic        memDone,     // done
    input wire logic        excTaken,    // exception
    input wire logic [3:0]  excCode      // cause
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    function automatic logic [7:0] lanes(logic [2:0] sz, logic [2:0] ad);
        return 8'(((16'h1 << (sz + 4'h1)) - 16'h1) << ad);
    endfunction
    sequence s_miss; memReq && !xlateHit; endsequence
    sequence s_wait; memReq && xlateHit && !memDone; endsequence
    property p_miss_trap; s_miss |=> excTaken && excCode == EXC_TRANSLATE; endproperty
    property p_miss_drop; s_miss |=> !memReq; endproperty
    property p_hold; s_wait |=> memReq; endproperty
    property p_stable; s_wait |=> $stable(memVirtAddr) && $stable(memByteEn); endproperty
    property p_lanes; memReq |-> memByteEn == lanes(memSize, memVirtAddr[2:0]); endproperty
    property p_lowbyte; memReq |-> memByteEn[memVirtAddr[2:0]]; endproperty
    property p_fill; memFill |-> !memWrite; endproperty
    property p_exc; excTaken |-> excCode != EXC_NONE ##1 !excTaken; endproperty
    a_miss_trap: assert property (p_miss_trap) else $error("miss not trapped");
    a_miss_drop: assert property (p_miss_drop) else $error("request kept after miss");
    a_hold: assert property (p_hold) else $error("request dropped early");
    a_stable: assert property (p_stable) else $error("access changed while pending");
    a_lanes: assert property (p_lanes) else $error("lane mask wrong");
    a_lowbyte: assert property (p_lowbyte) else $error("addressed byte not enabled");
    a_fill: assert property (p_fill) else $error("fill on store");
    a_exc: assert property (p_exc) else $error("exception pulse wrong");
endmodule
bind iab_core iab_core_monitor iab_core_monitor_i (.mclk, .rst_n, .memVirtAddr, .memReq, .memWrite, .memSize,
    .memByteEn, .memFill, .xlateHit, .memDone, .excTaken, .excCode);

// File: tb/iab_mem_model.sv
// partner: cache and memory side answering data accesses
`timescale 1ns/100ps
module iab_mem_model (
    input  wire logic   mclk,      // clock
    input  wire logic   rst_n,     // reset
    input  wire logic   memReq,    // request
    input  wire logic   missOn,    // force misses
    output logic        xlateHit,  // hit
    output logic        memDone,   // done pulse
    output logic [63:0] memRdData  // load data
);
    localparam logic [63:0] LOAD_WORD = 64'h0000_0000_7fff_ffff;
    integer seed = 32'h9869;
    int     waitN;
    logic   busy;
    assign xlateHit = !missOn;
    // whole word, valid only in the completing cycle
    assign memRdData = memDone ? LOAD_WORD : ~LOAD_WORD;
    // stores complete like loads, one at a time, slow or prompt
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            memDone <= 1'b0;
            busy <= 1'b0;
        end else if (memDone) begin
            memDone <= 1'b0;
            busy <= 1'b0;
        end else if (memReq && xlateHit && !busy) begin
            busy <= 1'b1;
            waitN <= int'($unsigned($random(seed)) % 3);
        end else if (busy && waitN == 0) begin
            memDone <= 1'b1;
        end else if (busy) begin
            waitN <= waitN - 1;
        end
    end
endmodule

// File: tb/tb_top.sv
// testbench: short programs run through the execution core
`timescale 1ns/100ps
module tb_top
    import iab_pkg::*;
();
    localparam logic [31:0] FILL = 32'h2400_0000;
    logic        mclk, rst_n, mode64, mode16, fetchValid, memCacheable, missOn, gotSlot;
    logic        fetchReq, memReq, memWrite, memFill, xlateHit, memDone, excTaken, excInSlot;
    logic [2:0]  memSize;
    logic [3:0]  excCode, gotCode;
    logic [7:0]  memByteEn, stEn[$];
    logic [31:0] fetchInstr, prog[16];
    logic [63:0] fetchAddr, memVirtAddr, memWrData, memRdData, excReturnAddr, gotRet, idx, a, stAddr[$], stData[$];
    integer      seed = 32'h9869;
    int          failures = 0;
    int          n_tests = 0;
    assign idx = (fetchAddr - PC_RESET) >> 2;
    assign fetchInstr = (idx < 64'h10) ? prog[idx[3:0]] : FILL;
    iab_core iab_core_i (.mclk, .rst_n, .mode64, .mode16, .fetchAddr, .fetchReq, .fetchInstr, .fetchValid,
        .memVirtAddr, .memReq, .memWrite, .memSize, .memByteEn, .memWrData, .memFill, .xlateHit,
        .memCacheable, .memDone, .memRdData, .excTaken, .excCode, .excReturnAddr, .excInSlot);
    iab_mem_model iab_mem_model_i (.mclk, .rst_n, .memReq, .missOn, .xlateHit, .memDone, .memRdData);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        fetchValid <= rst_n && fetchReq && ($random(seed) % 4 != 0);
        memCacheable <= 1'($random(seed));
        if (memReq && memDone && memWrite) begin
            stAddr.push_back(memVirtAddr);
            stData.push_back(memWrData);
            stEn.push_back(memByteEn);
        end
        if (excTaken && gotCode == EXC_NONE) begin
            gotCode <= excCode;
            gotRet <= excReturnAddr;
            gotSlot <= excInSlot;
        end
    end
    function automatic logic [31:0] ri(logic [5:0] op, logic [4:0] s, t, logic [15:0] im);
        return {op, s, t, im};
    endfunction
    function automatic logic [31:0] rr(logic [4:0] s, t, d, logic [5:0] fn);
        return {OP_SPECIAL, s, t, d, 5'h0, fn};
    endfunction
    function automatic logic [63:0] ext(logic m, logic [31:0] v);
        return m ? {{32{v[31]}}, v} : {32'h0, v};
    endfunction
    function automatic logic [7:0] lanes(logic [2:0] sz, logic [2:0] ad);
        return 8'(((16'h1 << (sz + 4'h1)) - 16'h1) << ad);
    endfunction
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // every program ends in an exception, which ends the wait; without one it gives up after 300 cycles
    task automatic run(logic m64, m16, miss);
        rst_n <= 1'b0;
        mode64 <= m64;
        mode16 <= m16;
        missOn <= miss;
        gotCode <= EXC_NONE;
        stAddr.delete();
        stData.delete();
        stEn.delete();
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 300 && gotCode == EXC_NONE; i++) @(posedge mclk);
        if (gotCode == EXC_NONE) begin
            failures++;
            test_done();
        end
    endtask
    task automatic one(logic [31:0] w0, w1, logic m16, miss, logic [3:0] code, logic full);
        foreach (prog[j]) prog[j] = FILL;
        prog[0] = w0;
        prog[1] = w1;
        run(1'b1, m16, miss);
        chk("code", 64'(code), 64'(gotCode));
        if (full) begin
            chk("slot", 64'(code == EXC_TRANSLATE), 64'(gotSlot));
            chk("ret", PC_RESET, gotRet);
        end
    endtask
    initial begin
        {rst_n, mode64, mode16, fetchValid, memCacheable, missOn} = 6'h0;
        gotCode = EXC_NONE;
        for (int m = 0; m < 2; m++) begin
            a = {61'h0, 1'($random(seed)), 2'h0};
            foreach (prog[j]) prog[j] = FILL;
            prog[0] = ri(OP_LOAD_WORD, 5'h0, 5'h2, 16'h0);
            prog[1] = rr(5'h2, 5'h2, 5'h3, FN_ADD_NOTRAP);
            prog[2] = ri(OP_ADD_IMMEDIATE_TRAPPING_NOTRAP, 5'h2, 5'h4, 16'h1);
            prog[3] = ri(OP_STORE_DWORD, 5'h0, 5'h3, 16'h8);
            prog[4] = ri(OP_STORE_WORD, 5'h0, 5'h4, a[15:0]);
            prog[5] = ri(OP_ADD_IMMEDIATE_TRAPPING_TRAP, 5'h0, 5'h5, 16'h8001);
            prog[6] = ri(OP_STORE_DWORD, 5'h0, 5'h5, 16'h10);
            prog[7] = rr(5'h2, 5'h2, 5'h6, FN_ADD_TRAP);
            run(1'(m), 1'b0, 1'b0);
            chk("code", 64'(EXC_OVERFLOW), 64'(gotCode));
            chk("ret", PC_RESET + 64'h1c, gotRet);
            chk("stores", 64'h3, 64'(stAddr.size()));
            chk("sd addr", 64'h8, stAddr[0]);
            chk("sd lanes", 64'(lanes(3'h7, 3'h0)), 64'(stEn[0]));
            chk("add_nontrapping", ext(1'(m), 32'hffff_fffe), stData[0]);
            chk("sw lanes", 64'(lanes(3'h3, a[2:0])), 64'(stEn[1]));
            chk("add_immediate_nontrapping", 64'h8000_0000, 64'(a[2] ? stData[1][63:32] : stData[1][31:0]));
            chk("add_immediate_trapping", ext(1'(m), 32'hffff_8001), stData[2]);
        end
        // no branch in the slot, and jumps never source the link register
        one(ri(OP_BRANCH_EQ, 5'h0, 5'h0, 16'h4), ri(OP_LOAD_WORD, 5'h0, 5'h1, 16'h0),
            1'b0, 1'b1, EXC_TRANSLATE, 1'b1);
        for (int k = 0; k < 2; k++) begin
            one(ri(OP_ADD_IMMEDIATE_TRAPPING_NOTRAP, 5'h0, 5'h1, 16'(2 - k)), rr(5'h1, 5'h0, 5'h0, FN_JUMP_REG),
                1'(k), 1'b0, EXC_ADDR_FETCH, 1'b0);
            one(ri(k ? OP_COP_STORE : OP_COP_LOAD, 5'h0, 5'h1, 16'h0), FILL,
                1'b0, 1'b0, EXC_RESERVED, 1'b1);
        end
        test_done();
    end
endmodule
